/* verilog/ppn_dev.sv */
/*
  Device end: decodes the programming pins, holds command, address and
  data, page buffers, flash, EEPROM, fuses and lock bits.
  Assumes the programmer keeps pin setup and hold times; all pins are
  asynchronous and pass the synchroniser first.
*/
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ppn_dev import ppn_pkg::*; #(
  parameter int BUSY_CYC = WLRH_CYC,
  parameter int FLASH_AW = FLASH_AW_DEF,
  parameter logic [7:0] FUSE_LO_INIT = 8'hFF,
  parameter logic [7:0] FUSE_HI_INIT = 8'hFF,
  parameter logic [7:0] FUSE_EXT_INIT = 8'hFF,
  parameter logic [7:0] SIG_B0 = 8'hA5, // Arbitrary value
  parameter logic [7:0] SIG_B1 = 8'h5A, // Arbitrary value
  parameter logic [7:0] SIG_B2 = 8'h3C, // Arbitrary value
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  ppn_if.dev PINS,
  output logic [7:0] FUSE_LO,
  output logic [7:0] FUSE_HI,
  output logic [7:0] FUSE_EXT,
  output logic [7:0] LOCK_BITS
);
  localparam int FPAGE = 1 << FPAGE_AW;
  localparam int EPAGE = 1 << EPAGE_AW;
  localparam int CW = $clog2(BUSY_CYC + 1);

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_COPY = 2'b01,
    S_WAIT = 2'b10
  } ppn_dstate_t;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection
  logic [15:0] s_pins;
  logic s_xtal, s_page_stb, s_wr_n, s_oe_n;
  logic [1:0] s_xa, s_bs;
  logic [7:0] s_data;
  logic xtal_q_r, page_stb_q_r, wr_q_r;
  logic xtal_rise, page_stb_rise, wr_fall;

  ppn_sync #(.WIDTH(16), .INIT(16'hC000)) u_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .d({PINS.wr_n, PINS.oe_n, PINS.load_strobe_pin, PINS.page_latch_strobe,
        PINS.load_action_sel_hi, PINS.load_action_sel_lo,
        PINS.byte_select_hi, PINS.byte_select_lo, PINS.data_bus}),
    .q(s_pins)
  );

  assign {s_wr_n, s_oe_n, s_xtal, s_page_stb, s_xa, s_bs, s_data} = s_pins;

  // Previous levels for edge detection
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      xtal_q_r <= 1'b0;
      page_stb_q_r <= 1'b0;
      wr_q_r <= 1'b1;
    end else begin
      xtal_q_r <= s_xtal;
      page_stb_q_r <= s_page_stb;
      wr_q_r <= s_wr_n;
    end
  end

  // One-cycle events
  assign xtal_rise = s_xtal & ~xtal_q_r;
  assign page_stb_rise = s_page_stb & ~page_stb_q_r;
  assign wr_fall = ~s_wr_n & wr_q_r;

  ////////////////////////////////////////////////////////////////////////
  // Command, address and data latches
  logic [7:0] cmd_r, addr_lo_r, addr_hi_r, addr_ext_r, dlo_r, dhi_r;
  logic [FLASH_AW-1:0] waddr;
  logic [EEP_AW-1:0] eaddr;
  logic nop_load;

  assign waddr = FLASH_AW'({addr_ext_r, addr_hi_r, addr_lo_r});
  assign eaddr = EEP_AW'({addr_hi_r, addr_lo_r});
  assign nop_load = xtal_rise && s_xa == XA_CMD && s_data == CMD_NOP;

  // Loads on strobe rise; values held until reloaded
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cmd_r <= CMD_NOP;
      addr_lo_r <= 8'h00;
      addr_hi_r <= 8'h00;
      addr_ext_r <= 8'h00;
      dlo_r <= BYTE_ERASED;
      dhi_r <= BYTE_ERASED;
    end else if (xtal_rise) begin
      case (s_xa)
        XA_ADDR: begin
          case (s_bs)
            BS_LOW: addr_lo_r <= s_data;
            BS_HIGH: addr_hi_r <= s_data;
            BS_EXT: addr_ext_r <= s_data;
            default: ;
          endcase
        end
        XA_DATA: begin
          if (s_bs[0]) begin
            dhi_r <= s_data;
          end else begin
            dlo_r <= s_data;
          end
        end
        XA_CMD: cmd_r <= s_data;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write sequencer and ready/busy
  ppn_dstate_t state_r;
  logic [CW-1:0] cnt_r;
  logic [FPAGE_AW-1:0] idx_r;
  logic prog_flash_r, rdy_r, prog_done;
  logic [7:0] fuse_lo_r, fuse_hi_r, fuse_ext_r, lock_r, lock_keep;
  logic start_page, start_fuse, start_lock, idle;

  assign idle = state_r == S_IDLE;
  assign start_page = idle && wr_fall && s_bs == BS_LOW &&
                      (cmd_r == CMD_WR_FLASH || cmd_r == CMD_WR_EEP);
  assign start_fuse = idle && wr_fall && cmd_r == CMD_WR_FUSE && s_bs != BS_FHIGH;
  assign start_lock = idle && wr_fall && cmd_r == CMD_WR_LOCK;
  assign prog_done = state_r == S_WAIT && cnt_r == CW'(BUSY_CYC - 1);
  // Boot lock bits frozen in lock mode 3
  assign lock_keep = ((lock_r & MAIN_LOCK_MASK) == 8'h00) ? BOOT_LOCK_MASK : 8'h00;

  // State, timer and copy index
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
      idx_r <= '0;
      prog_flash_r <= 1'b0;
      rdy_r <= 1'b1;
    end else begin
      case (state_r)
        S_IDLE: begin
          cnt_r <= '0;
          idx_r <= '0;
          if (start_page) begin
            state_r <= S_COPY;
            prog_flash_r <= cmd_r == CMD_WR_FLASH;
            rdy_r <= 1'b0;
          end else if (start_fuse || start_lock) begin
            state_r <= S_WAIT;
            rdy_r <= 1'b0;
          end
        end
        S_COPY: begin
          cnt_r <= cnt_r + 1'b1;
          idx_r <= idx_r + 1'b1;
          if (idx_r == FPAGE_AW'(prog_flash_r ? FPAGE - 1 : EPAGE - 1)) begin
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          cnt_r <= cnt_r + 1'b1;
          if (prog_done) begin
            state_r <= S_IDLE;
            rdy_r <= 1'b1;
          end
        end
        default: begin
          state_r <= S_IDLE;
          rdy_r <= 1'b1;
        end
      endcase
    end
  end

  // Fuse and lock storage
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      fuse_lo_r <= FUSE_LO_INIT;
      fuse_hi_r <= FUSE_HI_INIT;
      fuse_ext_r <= FUSE_EXT_INIT;
      lock_r <= BYTE_ERASED;
    end else begin
      if (start_fuse) begin
        case (s_bs)
          BS_LOW: fuse_lo_r <= dlo_r;
          BS_HIGH: fuse_hi_r <= dlo_r;
          BS_EXT: fuse_ext_r <= dlo_r;
          default: ;
        endcase
      end
      // Lock bits only ever move toward programmed
      if (start_lock) begin
        lock_r <= lock_r & (dlo_r | lock_keep);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Page buffers and memories
  logic [15:0] fbuf [FPAGE];
  logic [7:0] ebuf [EPAGE];
  logic [FPAGE-1:0] fvalid_r;
  logic [EPAGE-1:0] evalid_r;
  logic [15:0] flash_mem [1 << FLASH_AW];
  logic [7:0] eep_mem [1 << EEP_AW];
  logic [EPAGE_AW-1:0] eidx;

  assign eidx = idx_r[EPAGE_AW-1:0];

  // Page latch strobe fills buffers; nop or any finished write (page, fuse or lock) empties them
  always_ff @(posedge SYS_CLK) begin
    if (RST || nop_load || prog_done) begin
      fvalid_r <= '0;
      evalid_r <= '0;
    end
    // A latch in the clearing cycle still lands
    if (!RST && page_stb_rise && s_bs[0]) begin
      if (cmd_r == CMD_WR_FLASH) begin
        fbuf[waddr[FPAGE_AW-1:0]] <= {dhi_r, dlo_r};
        fvalid_r[waddr[FPAGE_AW-1:0]] <= 1'b1;
      end else if (cmd_r == CMD_WR_EEP) begin
        ebuf[eaddr[EPAGE_AW-1:0]] <= dlo_r;
        evalid_r[eaddr[EPAGE_AW-1:0]] <= 1'b1;
      end
    end
  end

  // Copy loaded words of the page into flash
  always_ff @(posedge SYS_CLK) begin
    if (state_r == S_COPY && prog_flash_r && fvalid_r[idx_r]) begin
      flash_mem[{waddr[FLASH_AW-1:FPAGE_AW], idx_r}] <= fbuf[idx_r];
    end
  end

  // Copy loaded bytes of the page into EEPROM
  always_ff @(posedge SYS_CLK) begin
    if (state_r == S_COPY && !prog_flash_r && evalid_r[eidx]) begin
      eep_mem[{eaddr[EEP_AW-1:EPAGE_AW], eidx}] <= ebuf[eidx];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path
  logic [7:0] dout_r, rd_byte;
  logic doe_r;
  logic [15:0] fword;

  assign fword = flash_mem[waddr];

  // Read data select by command and byte selects
  always_comb begin
    rd_byte = BYTE_ERASED;
    case (cmd_r)
      CMD_RD_FLASH: rd_byte = s_bs[0] ? fword[15:8] : fword[7:0];
      CMD_RD_EEP: begin
        if (!s_bs[0]) begin
          rd_byte = eep_mem[eaddr];
        end
      end
      CMD_RD_FUSE: begin
        case (s_bs)
          BS_LOW: rd_byte = fuse_lo_r;
          BS_FHIGH: rd_byte = fuse_hi_r;
          BS_EXT: rd_byte = fuse_ext_r;
          default: rd_byte = lock_r;
        endcase
      end
      CMD_RD_SIG: begin
        if (s_bs[0]) begin
          if (addr_lo_r == CAL_ADDR) begin
            rd_byte = CAL_BYTE;
          end
        end else if (addr_lo_r <= SIG_LAST) begin
          case (addr_lo_r[1:0])
            2'h0: rd_byte = SIG_B0;
            2'h1: rd_byte = SIG_B1;
            default: rd_byte = SIG_B2;
          endcase
        end
      end
      default: rd_byte = BYTE_ERASED;
    endcase
  end

  // Bus drive while output enable is low
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      dout_r <= BYTE_ERASED;
      doe_r <= 1'b0;
    end else begin
      dout_r <= rd_byte;
      doe_r <= ~s_oe_n;
    end
  end

  assign PINS.dev_data_o = dout_r;
  assign PINS.dev_data_oe = doe_r;
  assign PINS.ready_busy_out = rdy_r;
  assign FUSE_LO = fuse_lo_r;
  assign FUSE_HI = fuse_hi_r;
  assign FUSE_EXT = fuse_ext_r;
  assign LOCK_BITS = lock_r;
endmodule
`default_nettype wire

/* verilog/ppn_pkg.sv */
/*
  Shared constants of the parallel nonvolatile programming port: load
  actions, byte selects, command codes, memory geometry, pin timing and
  the programmer's own register map.
  Assumes a single 200 MHz system clock at both ends.
*/
`default_nettype none
package ppn_pkg;
  // Load action codes
  localparam logic [1:0] XA_ADDR = 2'h0;
  localparam logic [1:0] XA_DATA = 2'h1;
  localparam logic [1:0] XA_CMD = 2'h2;
  localparam logic [1:0] XA_IDLE = 2'h3;
  // Byte select pair {hi, lo}
  localparam logic [1:0] BS_LOW = 2'h0;
  localparam logic [1:0] BS_HIGH = 2'h1;
  localparam logic [1:0] BS_EXT = 2'h2;
  localparam logic [1:0] BS_FHIGH = 2'h3;
  // Command codes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEP = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEP = 8'h03;
  // Geometry
  localparam int FLASH_AW_DEF = 16;
  localparam int FPAGE_AW = 7;
  localparam int EEP_AW = 12;
  localparam int EPAGE_AW = 3;
  localparam logic [7:0] SIG_LAST = 8'h02;
  localparam logic [7:0] CAL_ADDR = 8'h00;
  localparam logic [7:0] MAIN_LOCK_MASK = 8'h03;
  localparam logic [7:0] BOOT_LOCK_MASK = 8'h3C;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_WLRH_NS = 3700000;
  localparam int T_DVXH_NS = 67;
  localparam int T_XHXL_NS = 150;
  localparam int T_XLDX_NS = 67;
  localparam int T_OLDV_NS = 250;
  localparam int T_OHDZ_NS = 250;
  // Wide product, the busy span in picoseconds overflows a plain int
  localparam int WLRH_CYC = int'((longint'(T_WLRH_NS) * 1000 + CLK_PERIOD_PS - 1) /
                                 CLK_PERIOD_PS);
  localparam int DVXH_CYC = (T_DVXH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int XHXL_CYC = (T_XHXL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int XLDX_CYC = (T_XLDX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OLDV_CYC = (T_OLDV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OHDZ_CYC = (T_OHDZ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_CYC = 3;
  // Programmer register map and fields
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_BS_LSB = 8;
  localparam int CMD_XA_LSB = 10;
  localparam int CMD_OP_LSB = 12;
  localparam int STAT_SEQ_BIT = 0;
  localparam int STAT_RDY_BIT = 1;
  localparam int STAT_RDATA_LSB = 8;
  localparam logic [2:0] OP_XTAL = 3'h1;
  localparam logic [2:0] OP_LATCH = 3'h2;
  localparam logic [2:0] OP_WR = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* verilog/ppn_if.sv */
/*
  Pin bundle between the programmer and the device.
  Assumes the data bus floats high when neither end drives it.
*/
`timescale 1ns/1ps
`default_nettype none
interface ppn_if;
  logic load_strobe_pin;
  logic load_action_sel_hi;
  logic load_action_sel_lo;
  logic byte_select_lo;
  logic byte_select_hi;
  logic page_latch_strobe;
  logic wr_n;
  logic oe_n;
  logic [7:0] host_data_o;
  logic host_data_oe;
  logic [7:0] dev_data_o;
  logic dev_data_oe;
  logic ready_busy_out;
  logic [7:0] data_bus;

  // Resolved bus level
  assign data_bus = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 8'hFF);

  modport dev (
    input load_strobe_pin, load_action_sel_hi, load_action_sel_lo, byte_select_lo,
    input byte_select_hi, page_latch_strobe, wr_n, oe_n, data_bus,
    output dev_data_o, dev_data_oe, ready_busy_out
  );
  modport host (
    output load_strobe_pin, load_action_sel_hi, load_action_sel_lo, byte_select_lo,
    output byte_select_hi, page_latch_strobe, wr_n, oe_n, host_data_o, host_data_oe,
    input data_bus, ready_busy_out
  );
endinterface
`default_nettype wire

/* verilog/ppn_sync.sv */
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes each bit is a slow level; bits are not sampled coherently.
*/
`timescale 1ns/1ps
`default_nettype none
module ppn_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // Two stages, only the second is read
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* verilog/ppn_host.sv */
/*
  Programmer end: an AXI4-Lite slave whose command register runs one pin
  step (strobe load, page latch, write pulse or read) with pin timing.
  Assumes software orders the steps; the device answers on ready/busy.
*/
`timescale 1ns/1ps
`default_nettype none
module ppn_host import ppn_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  ppn_if.host PINS
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SETUP = 2'b01,
    H_PULSE = 2'b10,
    H_HOLD = 2'b11
  } ppn_hstate_t;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r, pend_r, seq_busy, rdy_s;
  logic [3:0] awaddr_r;
  logic [1:0] wstrb_r;
  logic [31:0] wdata_r, rdata_r;
  logic [1:0] bresp_r, rresp_r;
  logic [7:0] rd_cap_r, bus_s;
  logic wr_ok;
  ppn_hstate_t st_r;

  assign S_AXI_AWREADY = ~aw_got_r & ~bvalid_r;
  assign S_AXI_WREADY = ~w_got_r & ~bvalid_r;
  assign S_AXI_ARREADY = ~rvalid_r;
  assign seq_busy = pend_r | (st_r != H_IDLE);
  assign wr_ok = awaddr_r == REG_CMD && wstrb_r == 2'h3 && !seq_busy;

  // Write channel: address and data in either order, then response
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bvalid_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 2'h0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB[1:0]; // Low two strobes kept with the data
      end
      if (aw_got_r && w_got_r) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel: status word
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_r <= 1'b1;
      rdata_r <= 32'h0;
      rresp_r <= RESP_SLVERR;
      if (S_AXI_ARADDR == REG_STAT) begin
        rresp_r <= RESP_OKAY;
        rdata_r[STAT_SEQ_BIT] <= seq_busy;
        rdata_r[STAT_RDY_BIT] <= rdy_s;
        rdata_r[STAT_RDATA_LSB +: 8] <= rd_cap_r;
      end
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  ////////////////////////////////////////////////////////////////////////
  // Pin step sequencer
  ppn_sync #(.WIDTH(9), .INIT(9'h1FF)) u_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .d({PINS.ready_busy_out, PINS.data_bus}),
    .q({rdy_s, bus_s})
  );

  logic [2:0] op_r;
  logic [1:0] xa_r, bs_r;
  logic [7:0] dat_r, cnt_r;
  logic xtal_r, page_stb_r, wr_n_r, oe_n_r, doe_r;
  logic is_rd;

  assign is_rd = op_r == OP_READ;

  // Step runs only once the device reports ready
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_r <= H_IDLE;
      pend_r <= 1'b0;
      op_r <= OP_XTAL;
      xa_r <= XA_IDLE;
      bs_r <= BS_LOW;
      dat_r <= 8'h00;
      cnt_r <= 8'h00;
      xtal_r <= 1'b0;
      page_stb_r <= 1'b0;
      wr_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      doe_r <= 1'b0;
      rd_cap_r <= 8'h00;
    end else begin
      if (aw_got_r && w_got_r && wr_ok) begin
        pend_r <= 1'b1;
        op_r <= wdata_r[CMD_OP_LSB +: 3];
        dat_r <= wdata_r[CMD_DATA_LSB +: 8];
        bs_r <= wdata_r[CMD_BS_LSB +: 2];
        xa_r <= wdata_r[CMD_XA_LSB +: 2];
      end
      if (st_r != H_IDLE && cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 1'b1;
      end
      case (st_r)
        H_IDLE: begin
          if (pend_r && rdy_s) begin
            pend_r <= 1'b0;
            st_r <= H_SETUP;
            doe_r <= !is_rd;
            cnt_r <= 8'(DVXH_CYC - 1);
          end
        end
        H_SETUP: begin
          if (cnt_r == 8'h00) begin
            st_r <= H_PULSE;
            xtal_r <= op_r == OP_XTAL;
            page_stb_r <= op_r == OP_LATCH;
            wr_n_r <= op_r != OP_WR;
            oe_n_r <= !is_rd;
            cnt_r <= is_rd ? 8'(OLDV_CYC + SYNC_CYC - 1) : 8'(XHXL_CYC - 1);
          end
        end
        H_PULSE: begin
          if (cnt_r == 8'h00) begin
            st_r <= H_HOLD;
            xtal_r <= 1'b0;
            page_stb_r <= 1'b0;
            wr_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            if (is_rd) begin
              rd_cap_r <= bus_s;
            end
            cnt_r <= is_rd ? 8'(OHDZ_CYC - 1) : 8'(XLDX_CYC - 1);
          end
        end
        H_HOLD: begin
          if (cnt_r == 8'h00) begin
            st_r <= H_IDLE;
            doe_r <= 1'b0;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign PINS.load_strobe_pin = xtal_r;
  assign PINS.page_latch_strobe = page_stb_r;
  assign PINS.wr_n = wr_n_r;
  assign PINS.oe_n = oe_n_r;
  assign {PINS.load_action_sel_hi, PINS.load_action_sel_lo} = xa_r;
  assign {PINS.byte_select_hi, PINS.byte_select_lo} = bs_r;
  assign PINS.host_data_o = dat_r;
  assign PINS.host_data_oe = doe_r;
endmodule
`default_nettype wire

/* verification/ppn_checker.sv */
/*
  Assertions on the pins between programmer and device.
  Assumes plain interface signals and the device busy length.
*/
`timescale 1ns/1ps
`default_nettype none
module ppn_checker import ppn_pkg::*; #(
  parameter int BUSY_CYC = WLRH_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic load_strobe_pin,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe,
  input wire logic ready_busy_out
);
  logic [31:0] low_cnt_r;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////
  // Busy span length
  always_ff @(posedge SYS_CLK) begin
    low_cnt_r <= ready_busy_out ? 32'h0 : low_cnt_r + 32'h1;
  end
  // Pin relations
  a_busy_len: assert property ($rose(ready_busy_out) |->
    low_cnt_r + 32'h1 >= BUSY_CYC && low_cnt_r <= BUSY_CYC + 1) else $error("busy length");
  a_busy_start: assert property ($fell(ready_busy_out) |-> !wr_n && !$past(wr_n, 3))
    else $error("busy without write");
  a_wr_ready: assert property ($fell(wr_n) |-> ready_busy_out)
    else $error("write while busy");
  a_oe_drive: assert property ($fell(oe_n) |-> ##[2:4] dev_data_oe)
    else $error("no read data");
  a_oe_release: assert property ($rose(oe_n) |-> ##[2:4] !dev_data_oe)
    else $error("read data held");
  a_no_clash: assert property (!(dev_data_oe && host_data_oe))
    else $error("bus clash");
  a_load_setup: assert property ($rose(load_strobe_pin) |-> $past(host_data_oe, 8))
    else $error("load setup short");
  a_load_hold: assert property ($fell(load_strobe_pin) |-> host_data_oe [*8])
    else $error("load hold short");
endmodule
`default_nettype wire

/* verification/ppn_tb_top.sv */
/*
  Bench: programmer end over AXI4-Lite, device end on the pins.
  Assumes a 5 ns clock and a shortened device busy time.
*/
`timescale 1ns/1ps
`default_nettype none
module ppn_tb_top import ppn_pkg::*; ();
  localparam int BUSY = 200;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st;
  logic [1:0] bresp, rresp, br;
  logic [7:0] fuse_lo, fuse_hi, fuse_ext, lock_bits;
  int err_total, checks_done;
  // Rows: bit 24 compare, [23:16] expected byte, [15:0] command word
  logic [24:0] rows [46] = '{25'h0001840, 25'h00014F3, 25'h0003100, 25'h0003200,
    25'h0003000, 25'h0001804, 25'h1F34300, 25'h1F34000, 25'h1F34200, 25'h0001808,
    25'h0001001, 25'h15A4000, 25'h0001000, 25'h1804100, 25'h0001810, 25'h0001101,
    25'h00014AA, 25'h0001569, 25'h0002100, 25'h0003000, 25'h0001800, 25'h0001802,
    25'h1AA4000, 25'h1694100, 25'h0001811, 25'h0001455, 25'h0002100, 25'h0003000,
    25'h0001803, 25'h1554000, 25'h0001820, 25'h00014FC, 25'h0003000, 25'h00014C3,
    25'h0003000, 25'h0001804, 25'h1FC4100, 25'h1F34300, 25'h0001810, 25'h0001411,
    25'h0002100, 25'h0001800, 25'h0001810, 25'h0003000, 25'h0001802, 25'h1AA4000};
  ppn_if pins();
  ppn_host u_ppn_host (.SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .PINS(pins.host));
  ppn_dev #(.BUSY_CYC(BUSY)) u_ppn_dev (.SYS_CLK(clk), .RST(rst), .PINS(pins.dev),
    .FUSE_LO(fuse_lo), .FUSE_HI(fuse_hi), .FUSE_EXT(fuse_ext), .LOCK_BITS(lock_bits));
  ppn_checker #(.BUSY_CYC(BUSY)) u_ppn_checker (.SYS_CLK(clk), .RST(rst),
    .load_strobe_pin(pins.load_strobe_pin), .wr_n(pins.wr_n), .oe_n(pins.oe_n),
    .host_data_oe(pins.host_data_oe), .dev_data_oe(pins.dev_data_oe),
    .ready_busy_out(pins.ready_busy_out));
  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One AXI write or read, answer kept in br and st
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
    logic done, ra, rw, rr;
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      ra = awready;
      rw = wready;
      rr = arready;
      done = bvalid || rvalid;
      br = bvalid ? bresp : rresp;
      st = rdata;
      @(posedge clk);
      if (ra) awvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
      if (rr) arvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
  endtask
  // Wait for idle sequencer and ready device
  task automatic poll();
    st = 32'h1;
    while (st[1:0] !== 2'b10) axi(1'b0, REG_STAT, 32'h0);
  endtask
  task automatic step(input logic [15:0] c);
    axi(1'b1, REG_CMD, {16'h0, c});
    poll();
  endtask
  // Verdict
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 40'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(32'(pins.ready_busy_out), 32'h1);
    foreach (rows[i]) begin
      step(rows[i][15:0]);
      if (rows[i][24]) chk(32'(st[15:8]), 32'(rows[i][23:16]));
    end
    chk(32'({fuse_lo, fuse_hi, fuse_ext}), 32'hF3F3F3);
    chk(32'(lock_bits), 32'hFC);
    axi(1'b1, 4'h8, 32'h0);
    chk(32'(br), 32'(RESP_SLVERR));
    axi(1'b0, REG_CMD, 32'h0);
    chk(32'(br), 32'(RESP_SLVERR));
    axi(1'b1, REG_CMD, 32'h1800);
    chk(32'(br), 32'(RESP_OKAY));
    axi(1'b1, REG_CMD, 32'h1800);
    chk(32'(br), 32'(RESP_SLVERR));
    poll();
    // Reset after the last step ends, then idle status
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(32'(pins.ready_busy_out), 32'h1);
    poll();
    chk(st, 32'h2);
    wrap_up();
  end
endmodule
`default_nettype wire
